// [logic/cpg_top.sv]
// Top of the cascadable pulse generator: one group of four channels with APB registers.
// Assumes gate and timing inputs synchronous to core_clk; outputs feed a timer output stage.
`timescale 1ns/1ps
module cpg_top #(
  parameter int TG_W = 8
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // APB slave
  input wire cpg_pkg::cpg_apb_req_s apb_req,
  output cpg_pkg::cpg_apb_rsp_s apb_rsp,
  // Gate levels from the multifunction timer unit
  input wire logic [cpg_pkg::NCH-1:0] gate_in,
  // Pulse outputs, per-channel interrupt pulses and timing-generator start levels
  output logic [cpg_pkg::NCH-1:0] pulse_out,
  output logic [cpg_pkg::NCH-1:0] irq_out,
  output logic [cpg_pkg::NCH-1:0] tg_start_out
);
  import cpg_pkg::*;

  // Timing counter is compared against one byte per channel
  if (TG_W < 1 || TG_W > 8) begin : g_bad_tg_w
    $error("TG_W must be 1 to 8");
  end

  typedef struct packed {
    logic [NCH-1:0][15:0] width;
    logic [CTRL_W-1:0] ctrl;
    logic [NCH-1:0] run;
    logic [31:0] tgcmp;
    logic [TG_W-1:0] tg_cnt;
    logic [NCH-1:0] tg_start;
    cpg_chan_s [NCH-1:0] chan;
    logic [NCH-1:0] pulse;
    logic [NCH-1:0] irq;
    cpg_apb_rsp_s rsp;
  } cpg_state_s;

  cpg_state_s q, d;
  logic [1:0] rst_sync_q;
  logic rst_n_int;

  function automatic logic [5:0] div_limit(input logic [1:0] sel);
    case (sel)
      2'b00: div_limit = DIV_LIM_1;
      2'b01: div_limit = DIV_LIM_4;
      2'b10: div_limit = DIV_LIM_16;
      default: div_limit = DIV_LIM_64;
    endcase
  endfunction : div_limit

  // Prohibited pair codes fall back to independent channels
  function automatic cpg_mode_e eff_mode(input logic [CTRL_W-1:0] c, input int p);
    logic quad;
    logic [1:0] md;
    quad = (c[CTRL_MODE_POS +: 2] == 2'b11) && (c[CTRL_MODE_POS + 2 +: 2] == 2'b11);
    md = c[CTRL_MODE_POS + 2 * p +: 2];
    if (quad) begin
      eff_mode = MODE_1616;
    end else if (md == 2'b11) begin
      eff_mode = MODE_8;
    end else begin
      eff_mode = cpg_mode_e'(md);
    end
  endfunction : eff_mode

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'b00) && (a <= OFS_STATUS);
  endfunction : addr_ok

  always_comb begin
    logic acc;
    logic wr;
    logic [31:0] rdata;
    logic [NCH-1:0] tog;
    logic [NCH-1:0] lvl_now;
    cpg_mode_e em;
    logic chained;
    logic outside;
    logic start;
    logic tick;
    logic divtick;
    logic [1:0] src;
    logic [15:0] wl;
    logic [15:0] wh;
    logic [15:0] cnt;
    logic [15:0] ncnt;
    logic nlvl;
    logic nrun;
    logic [5:0] ndiv;
    int up;
    int pre;
    acc = 1'b0;
    wr = 1'b0;
    rdata = 32'h00000000;
    tog = '0;
    lvl_now = '0;
    em = MODE_8;
    chained = 1'b0;
    outside = 1'b0;
    start = 1'b0;
    tick = 1'b0;
    divtick = 1'b0;
    src = 2'b00;
    wl = 16'h0000;
    wh = 16'h0000;
    cnt = 16'h0000;
    ncnt = 16'h0000;
    nlvl = 1'b0;
    nrun = 1'b0;
    ndiv = 6'h00;
    up = 0;
    pre = 0;
    d = q;

    // One wait state: ready in the second access cycle, write lands there
    acc = apb_req.psel & apb_req.penable;
    wr = acc & q.rsp.pready & apb_req.pwrite & addr_ok(apb_req.paddr);
    case (apb_req.paddr)
      OFS_CTRL: rdata = 32'(q.ctrl);
      OFS_RUN: rdata = 32'(q.run);
      OFS_TGCMP: rdata = q.tgcmp;
      OFS_STATUS: begin
        for (int k = 0; k < NCH; k++) begin
          rdata[STATUS_LVL_POS + k] = q.chan[k].lvl;
          rdata[STATUS_RUN_POS + k] = q.chan[k].run;
        end
        rdata[STATUS_TG_POS +: 8] = 8'(q.tg_cnt);
      end
      default: begin
        if (addr_ok(apb_req.paddr)) begin
          rdata = {16'h0000, q.width[apb_req.paddr[3:2]]};
        end
      end
    endcase
    d.rsp.pready = acc & ~q.rsp.pready;
    d.rsp.pslverr = acc & ~q.rsp.pready & ~addr_ok(apb_req.paddr);
    d.rsp.prdata = (acc & ~q.rsp.pready & ~apb_req.pwrite) ? rdata : 32'h00000000;
    if (wr) begin
      case (apb_req.paddr)
        OFS_CTRL: d.ctrl = apb_req.pwdata[CTRL_W-1:0];
        OFS_RUN: d.run = apb_req.pwdata[NCH-1:0];
        OFS_TGCMP: d.tgcmp = apb_req.pwdata;
        OFS_STATUS: d.ctrl = q.ctrl;
        default: d.width[apb_req.paddr[3:2]] = apb_req.pwdata[15:0];
      endcase
    end

    if (q.ctrl[CTRL_TGEN_POS]) begin
      d.tg_cnt = q.tg_cnt + 1'b1;
      for (int k = 0; k < NCH; k++) begin
        if (q.tg_cnt == q.tgcmp[8 * k +: TG_W]) begin
          d.tg_start[k] = 1'b1;
        end
      end
    end else begin
      d.tg_cnt = '0;
      d.tg_start = '0;
    end

    // Descending so prescaler toggles are known before output sides
    for (int k = NCH - 1; k >= 0; k--) begin
      em = eff_mode(q.ctrl, k / 2);
      chained = (em == MODE_16) || (em == MODE_1616);
      up = k | 1;
      if (!(chained && (k % 2 == 1))) begin
        src = q.ctrl[CTRL_SRC_POS + 2 * (k / 2) +: 2];
        if (em == MODE_88 || em == MODE_1616 || (k % 2 == 1) || src == SRC_RUN) begin
          start = q.run[k];
        end else if (src == SRC_GATE) begin
          start = gate_in[k];
        end else if (src == SRC_TG) begin
          start = q.tg_start[k];
        end else begin
          start = q.run[k];
        end
        // out side counts each prescaler toggle
        outside = ((em == MODE_88) && (k % 2 == 0)) || ((em == MODE_1616) && (k == 0));
        pre = (em == MODE_88) ? up : 2;
        divtick = q.chan[k].div == div_limit(q.ctrl[CTRL_CKS_POS + 2 * k +: 2]);
        tick = outside ? tog[pre] : divtick;
        // even lower byte, odd upper byte
        if (chained) begin
          wl = {q.width[up][WIDTH_LO_POS +: 8], q.width[k][WIDTH_LO_POS +: 8]};
          wh = {q.width[up][WIDTH_HI_POS +: 8], q.width[k][WIDTH_HI_POS +: 8]};
          cnt = {q.chan[up].cnt, q.chan[k].cnt};
        end else begin
          wl = {8'h00, q.width[k][WIDTH_LO_POS +: 8]};
          wh = {8'h00, q.width[k][WIDTH_HI_POS +: 8]};
          cnt = {8'h00, q.chan[k].cnt};
        end
        ncnt = cnt;
        nlvl = q.chan[k].lvl;
        nrun = q.chan[k].run;
        ndiv = q.chan[k].div;
        if (!start) begin
          nrun = 1'b0;
          nlvl = 1'b0;
          ncnt = 16'h0000;
          ndiv = 6'h00;
        end else if (!q.chan[k].run) begin
          nrun = 1'b1;
          nlvl = 1'b0;
          ncnt = wl;
          ndiv = 6'h00;
        end else begin
          ndiv = divtick ? 6'h00 : q.chan[k].div + 6'h01;
          if (tick) begin
            // reload plus one ticks per phase
            if (cnt == 16'h0000) begin
              nlvl = ~q.chan[k].lvl;
              ncnt = nlvl ? wh : wl;
            end else begin
              ncnt = cnt - 16'h0001;
            end
          end
        end
        tog[k] = nlvl ^ q.chan[k].lvl;
        d.chan[k] = '{run: nrun, lvl: nlvl, cnt: ncnt[7:0], div: ndiv};
        lvl_now[k] = nlvl;
        if (chained) begin
          tog[up] = tog[k];
          d.chan[up] = '{run: nrun, lvl: nlvl, cnt: ncnt[15:8], div: 6'h00};
          lvl_now[up] = nlvl;
        end
      end
    end

    d.pulse = lvl_now ^ q.ctrl[CTRL_INV_POS +: NCH];
    d.irq = d.pulse ^ q.pulse;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n_int = rst_sync_q[1];

  always_ff @(posedge core_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      q <= '0;
      q.width <= {NCH{WIDTH_RST}};
      q.ctrl <= CTRL_RST;
      q.run <= RUN_RST;
      q.tgcmp <= TGCMP_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign apb_rsp = q.rsp;
  assign pulse_out = q.pulse;
  assign irq_out = q.irq;
  assign tg_start_out = q.tg_start;
endmodule : cpg_top

// [logic/cpg_pkg.sv]
// Package for the cascadable pulse generator: register map, fields, reset values, modes and bus carriers.
// Assumes a 32-bit APB slave with byte addresses on the low eight address bits.
package cpg_pkg;
  localparam int NCH = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_WIDTH0 = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_RUN = 8'h14;
  localparam logic [7:0] OFS_TGCMP = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // Field positions
  localparam int WIDTH_LO_POS = 0;
  localparam int WIDTH_HI_POS = 8;
  localparam int CTRL_MODE_POS = 0;
  localparam int CTRL_SRC_POS = 4;
  localparam int CTRL_CKS_POS = 8;
  localparam int CTRL_INV_POS = 16;
  localparam int CTRL_TGEN_POS = 20;
  localparam int CTRL_W = 21;
  localparam int STATUS_LVL_POS = 0;
  localparam int STATUS_RUN_POS = 4;
  localparam int STATUS_TG_POS = 8;

  // Reset values
  localparam logic [15:0] WIDTH_RST = 16'h0000;
  localparam logic [CTRL_W-1:0] CTRL_RST = 21'h000000;
  localparam logic [NCH-1:0] RUN_RST = 4'h0;
  localparam logic [31:0] TGCMP_RST = 32'h00000000;

  // Divider terminal counts for 1, 4, 16, 64 peripheral cycles
  localparam logic [5:0] DIV_LIM_1 = 6'h00;
  localparam logic [5:0] DIV_LIM_4 = 6'h03;
  localparam logic [5:0] DIV_LIM_16 = 6'h0f;
  localparam logic [5:0] DIV_LIM_64 = 6'h3f;

  typedef enum logic [1:0] {
    MODE_8 = 2'b00,
    MODE_88 = 2'b01,
    MODE_16 = 2'b10,
    MODE_1616 = 2'b11
  } cpg_mode_e;

  typedef enum logic [1:0] {
    SRC_RUN = 2'b00,
    SRC_GATE = 2'b01,
    SRC_TG = 2'b10
  } cpg_src_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cpg_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cpg_apb_rsp_s;

  typedef struct packed {
    logic run;
    logic lvl;
    logic [7:0] cnt;
    logic [5:0] div;
  } cpg_chan_s;
endpackage : cpg_pkg

// [dv/cpg_far_model.sv]
// Far side: timer output stage giving the gate level.
// Assumes the bench sets gate_cmd at rising edges.
`timescale 1ns/1ps
module cpg_far_model (
  // Clock, reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bench command
  input wire logic gate_cmd,
  // Gate level to the block
  output logic [cpg_pkg::NCH-1:0] gate_in
);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gate_in <= '0;
    end else begin
      gate_in <= {3'b000, gate_cmd};
    end
  end
endmodule : cpg_far_model

// [dv/cpg_top_checker.sv]
// Checker of the top ports: APB answer, interrupts, starts.
// Bound from the bench top; one clock domain.
`timescale 1ns/1ps
module cpg_top_checker #(
  parameter int TG_W = 8
) (
  // Watched ports
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire cpg_pkg::cpg_apb_req_s apb_req,
  input wire cpg_pkg::cpg_apb_rsp_s apb_rsp,
  input wire logic [cpg_pkg::NCH-1:0] gate_in,
  input wire logic [cpg_pkg::NCH-1:0] pulse_out,
  input wire logic [cpg_pkg::NCH-1:0] irq_out,
  input wire logic [cpg_pkg::NCH-1:0] tg_start_out
);
  import cpg_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_PRDY_ONE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  AST_PRDY_WAIT: assert property (apb_req.psel && !apb_req.penable |-> ##2 apb_rsp.pready)
    else $error("pready not two cycles after setup");
  AST_PRDY_ACC: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
    else $error("pready outside access");
  AST_ERR_UNAL: assert property (apb_rsp.pready && apb_req.paddr[1:0] != 2'b00 |-> apb_rsp.pslverr)
    else $error("unaligned access not refused");
  AST_WR_ZERO: assert property (apb_rsp.pready && apb_req.pwrite |-> apb_rsp.prdata == 32'h0)
    else $error("read data on a write");
  AST_IRQ_EDGE: assert property (irq_out == (pulse_out ^ $past(pulse_out)))
    else $error("interrupt not tied to output change");
  AST_TG_HOLD: assert property ($fell(tg_start_out[0]) |-> $past(apb_req.pwrite && apb_rsp.pready, 2))
    else $error("start dropped without a write");
  AST_RST_IDLE: assert property (disable iff (1'b0) !rstn |-> pulse_out == '0 && irq_out == '0)
    else $error("output not idle in reset");
  cover property (apb_rsp.pslverr);
  cover property (irq_out[0]);
  cover property ($rose(tg_start_out[0]));
  cover property (!ce && pulse_out[2]);
endmodule : cpg_top_checker

// [dv/tb_cascadable_pulse_generator.sv]
// Bench for the pulse generator top: APB master and scenarios.
// Assumes one-wait-state APB and registered outputs.
`timescale 1ns/1ps
module tb_cascadable_pulse_generator;
  import cpg_pkg::*;
  logic core_clk, rstn, gate_cmd, err, ce;
  cpg_apb_req_s req;
  cpg_apb_rsp_s rsp;
  logic [NCH-1:0] gate_in, pulse_out, irq_out, tg_start_out;
  logic [31:0] rdv, h, l;
  int mismatches, checked;
  cpg_top cpg_top_i (.core_clk, .rstn, .ce, .apb_req(req), .apb_rsp(rsp), .gate_in, .pulse_out,
    .irq_out, .tg_start_out);
  cpg_far_model cpg_far_model_i (.core_clk, .rstn, .gate_cmd, .gate_in);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do begin @(posedge core_clk); n++; end while (rsp.pready !== 1'b1 && n < 20);
    if (n == 20) begin
      mismatches++;
      $display("Error at %0t: no pready", $time);
    end
    rdv = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge core_clk);
  endtask : xfer
  task automatic meas(input int ch);
    int n;
    n = 0;
    while (pulse_out[ch] !== 1'b1 && n < 2000) begin @(posedge core_clk); n++; end
    h = 0;
    while (pulse_out[ch] === 1'b1 && h < 2000) begin @(posedge core_clk); h++; end
    l = 0;
    while (pulse_out[ch] === 1'b0 && l < 2000) begin @(posedge core_clk); l++; end
  endtask : meas
  task automatic stop_chk(input int ch, input logic [7:0] a);
    xfer(1'b1, a, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(32'(pulse_out[ch]), 32'h0);
  endtask : stop_chk
  task automatic t_8bit();
    xfer(1'b1, OFS_WIDTH0, 32'h0302);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, OFS_CTRL, 32'(k) << CTRL_CKS_POS);
      xfer(1'b1, OFS_RUN, 32'h1);
      meas(0);
      chk(h, 32'(4 << (2 * k)));
      chk(l, 32'(3 << (2 * k)));
      stop_chk(0, OFS_RUN);
    end
    $display("t_8bit done");
  endtask : t_8bit
  task automatic t_16();
    xfer(1'b1, OFS_CTRL, 32'h8);
    xfer(1'b1, 8'h08, 32'h0100);
    xfer(1'b1, 8'h0c, 32'h0001);
    xfer(1'b1, OFS_RUN, 32'hc);
    meas(2);
    chk(h, 32'd2);
    chk(l, 32'd257);
    // Clock enable low must hold the High level
    ce <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk(32'(pulse_out[2]), 32'h1);
    ce <= 1'b1;
    stop_chk(2, OFS_RUN);
    $display("t_16 done");
  endtask : t_16
  task automatic t_88();
    xfer(1'b1, OFS_CTRL, 32'h1);
    xfer(1'b1, 8'h04, 32'h0101);
    xfer(1'b1, OFS_RUN, 32'h3);
    meas(0);
    chk(h, 32'd8);
    chk(l, 32'd6);
    stop_chk(0, OFS_RUN);
    $display("t_88 done");
  endtask : t_88
  task automatic t_src();
    xfer(1'b1, OFS_CTRL, 32'h10);
    gate_cmd <= 1'b1;
    meas(0);
    chk(h, 32'd4);
    gate_cmd <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(32'(pulse_out[0]), 32'h0);
    xfer(1'b1, OFS_TGCMP, 32'h05);
    xfer(1'b1, OFS_CTRL, 32'h100020);
    meas(0);
    chk(l, 32'd3);
    chk(32'(tg_start_out[0]), 32'h1);
    stop_chk(0, OFS_CTRL);
    $display("t_src done");
  endtask : t_src
  task automatic t_1616();
    // both pair modes set before start
    xfer(1'b1, OFS_CTRL, 32'hf);
    xfer(1'b1, OFS_WIDTH0, 32'h0100);
    xfer(1'b1, 8'h04, 32'h0001);
    xfer(1'b1, 8'h08, 32'h0101);
    xfer(1'b1, 8'h0c, 32'h0000);
    xfer(1'b1, OFS_RUN, 32'hf);
    meas(0);
    chk(h, 32'd4);
    chk(l, 32'd514);
    stop_chk(0, OFS_RUN);
    xfer(1'b1, OFS_CTRL, 32'h0);
    $display("t_1616 done");
  endtask : t_1616
  task automatic t_inv();
    chk(32'(pulse_out), 32'h0);
    xfer(1'b1, OFS_CTRL, 32'h10000);
    @(posedge core_clk);
    chk(32'(irq_out[0]), 32'h1);
    @(posedge core_clk);
    chk(32'(pulse_out[0]), 32'h1);
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rdv & 32'h1, 32'h0);
    xfer(1'b1, OFS_STATUS, 32'hf);
    chk(32'(err), 32'h0);
    xfer(1'b1, 8'h20, 32'h0);
    chk(32'(err), 32'h1);
    xfer(1'b0, 8'h02, 32'h0);
    chk(32'(err), 32'h1);
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk(rdv, 32'h10000);
    xfer(1'b1, OFS_CTRL, 32'h0);
    $display("t_inv done");
  endtask : t_inv
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end
  initial begin
    rstn = 1'b1;
    gate_cmd = 1'b0;
    ce = 1'b1;
    req = '0;
    // Falling edge after time zero so the asynchronous reset is seen
    #1 rstn = 1'b0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_inv();
    t_8bit();
    t_16();
    t_88();
    t_src();
    t_1616();
    end_sim();
  end
endmodule : tb_cascadable_pulse_generator
bind cpg_top cpg_top_checker #(.TG_W(TG_W)) cpg_top_checker_i (.core_clk, .rstn, .ce, .apb_req, .apb_rsp,
  .gate_in, .pulse_out, .irq_out, .tg_start_out);
